// File: logic/watchdog_reload_unlock.sv
// Watchdog reload unlock sequencer with APB register access
// Summary of operation
// - Unlock control register is write-only; reads never return its contents.
// - Writing 55h then aah unlocks the three reload byte registers.
// - Key writes only advance the sequence; nothing is stored.
// - Control at index ff0; writes go to unlock, reads return reset status.
// - Reload byte writes are ignored while locked.
// - Any interrupting register write relocks until restarted from first key.
//
// The APB register port was left to the implementer.
`timescale 1ns/10ps
module watchdog_reload_unlock
(
  input  wire logic                               ref_clk,
  input  wire logic                               rst,
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [wdt_unlock_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [wdt_unlock_pkg::DATA_W-1:0]  pwdata,
  input  wire logic [3:0]                         pstrb,
  output logic      [wdt_unlock_pkg::DATA_W-1:0]  prdata,
  output logic                                    pready,
  output logic                                    pslverr,
  input  wire logic [7:0]                         reset_status,
  input  wire logic [23:0]                        count_value,
  output logic      [23:0]                        reload_value,
  output logic                                    reload_update,
  output logic                                    unlocked
);
  import wdt_unlock_pkg::*;

  lock_state_t                state_q;
  lock_state_t                state_d;
  logic [23:0]                reload_q;
  logic [23:0]                reload_d;
  logic                       update_q;
  logic                       update_d;
  logic [DATA_W-1:0]          prdata_q;
  logic [DATA_W-1:0]          prdata_d;
  logic                       pready_q;
  logic                       pready_d;
  logic                       pslverr_q;
  logic                       pslverr_d;
  logic                       setup;
  logic                       wr_en;
  logic                       hit_ctrl;
  logic                       hit_upper;
  logic                       hit_high;
  logic                       hit_low;
  logic                       mapped;
  logic [7:0]                 wbyte;
  logic                       unlocked_q;
  logic                       unlocked_d;
  logic                       low_done;

  assign setup     = psel && !penable;
  // Write commits only at the access edge where pready is seen high
  assign wr_en     = psel && penable && pready_q && pwrite;
  // Full-width compare so no alias of these words can advance the sequence
  assign hit_ctrl  = (paddr == CTRL_ADDR);
  assign hit_upper = (paddr == UPPER_ADDR);
  assign hit_high  = (paddr == HIGH_ADDR);
  assign hit_low   = (paddr == LOW_ADDR);
  assign mapped    = hit_ctrl || hit_upper || hit_high || hit_low;
  // Registers are one byte wide; lane 0 must be strobed for the byte to be taken
  assign wbyte     = pwdata[7:0];
  // Completing low byte write; only the checks below read it
  assign low_done  = wr_en && hit_low && pstrb[0] && (state_q == ST_WANT_LOW);

  // Bus response: no wait state; read data is registered from a flip-flop in the setup cycle
  always_comb
  begin
    pready_d  = setup;
    pslverr_d = 1'b0;
    prdata_d  = prdata_q;
    if (setup)
    begin
      pslverr_d = !mapped;
      prdata_d  = '0;
      if (!pwrite)
      begin
        if (hit_ctrl)
          prdata_d = {24'h000000, reset_status};
        // Reload reads show the live count, not the value written
        else if (hit_upper)
          prdata_d = {24'h000000, count_value[UPPER_LSB +: 8]};
        else if (hit_high)
          prdata_d = {24'h000000, count_value[HIGH_LSB +: 8]};
        else if (hit_low)
          prdata_d = {24'h000000, count_value[LOW_LSB +: 8]};
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end
    else
    begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
    end
  end

  // Lock sequencer; any write is an event, reads never disturb it
  always_comb
  begin
    state_d  = state_q;
    reload_d = reload_q;
    update_d = 1'b0;
    if (wr_en)
    begin
      state_d = ST_LOCKED;
      if (hit_ctrl && pstrb[0])
      begin
        if (state_q == ST_KEY1 && wbyte == KEY_SECOND)
          state_d = ST_WANT_UPPER;
        else if (wbyte == KEY_FIRST)
          state_d = ST_KEY1;
      end
      else if (pstrb[0])
      begin
        unique case (state_q)
          ST_WANT_UPPER:
          begin
            if (hit_upper)
            begin
              reload_d[UPPER_LSB +: 8] = wbyte;
              state_d                  = ST_WANT_HIGH;
            end
          end
          ST_WANT_HIGH:
          begin
            if (hit_high)
            begin
              reload_d[HIGH_LSB +: 8] = wbyte;
              state_d                 = ST_WANT_LOW;
            end
          end
          ST_WANT_LOW:
          begin
            if (hit_low)
            begin
              reload_d[LOW_LSB +: 8] = wbyte;
              update_d               = 1'b1;
            end
          end
          // A reload write before the key pair is a stray write
          ST_LOCKED, ST_KEY1:
          begin
            state_d = ST_LOCKED;
          end
        endcase
      end
    end
    // Flag follows the next state so it leaves a flip-flop without lag
    unlocked_d = (state_d == ST_WANT_UPPER) || (state_d == ST_WANT_HIGH) || (state_d == ST_WANT_LOW);
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_q    <= ST_LOCKED;
      reload_q   <= RELOAD_RST;
      update_q   <= 1'b0;
      unlocked_q <= 1'b0;
    end
    else
    begin
      state_q    <= state_d;
      reload_q   <= reload_d;
      update_q   <= update_d;
      unlocked_q <= unlocked_d;
    end
  end

  assign prdata        = prdata_q;
  assign pready        = pready_q;
  assign pslverr       = pslverr_q;
  assign reload_value  = reload_q;
  assign reload_update = update_q;
  // Unlocked shown once the key pair has been accepted
  assign unlocked      = unlocked_q;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // Single write events; the properties chain them with the lock state
  sequence wr_ctrl_key(logic [7:0] k);
    wr_en && hit_ctrl && pstrb[0] && wbyte == k;
  endsequence

  sequence wr_reload(logic hit);
    wr_en && hit && pstrb[0];
  endsequence

  chk_first_key: assert property (
    wr_ctrl_key(KEY_FIRST) |=> state_q == ST_KEY1)
    else $error("first key did not arm sequence");

  chk_key_pair: assert property (
    ((state_q == ST_KEY1) and wr_ctrl_key(KEY_SECOND)) |=> unlocked)
    else $error("key pair did not unlock");

  chk_ctrl_no_store: assert property (
    wr_en && hit_ctrl |=> $stable(reload_q) && !update_q)
    else $error("control write altered reload");

  chk_status_read: assert property (
    setup && !pwrite && hit_ctrl |=> prdata == {24'h000000, $past(reset_status)} && pready)
    else $error("control read did not return reset status");

  chk_ctrl_write_only: assert property (
    psel && penable && !pwrite && hit_ctrl && pready |-> prdata[31:8] == 24'h000000)
    else $error("control read exposed upper bits");

  chk_locked_drop: assert property (
    !unlocked && wr_en && (hit_upper || hit_high || hit_low) |=> $stable(reload_q) && !unlocked)
    else $error("reload changed while locked");

  chk_other_relock: assert property (
    wr_en && !mapped |=> state_q == ST_LOCKED)
    else $error("foreign write did not relock");

  chk_low_relock: assert property (
    ((state_q == ST_WANT_LOW) and wr_reload(hit_low)) |=> state_q == ST_LOCKED && update_q
      && reload_q[7:0] == $past(wbyte) ##1 !update_q)
    else $error("low byte did not complete and relock");

  chk_wrong_key: assert property (
    state_q == ST_KEY1 && wr_en && hit_ctrl && pstrb[0] && wbyte != KEY_SECOND && wbyte != KEY_FIRST
      |=> state_q == ST_LOCKED)
    else $error("wrong key did not relock");

  chk_upper_order: assert property (
    ((state_q == ST_WANT_UPPER) and wr_reload(hit_high)) |=> state_q == ST_LOCKED && $stable(reload_q))
    else $error("out of order write accepted");

  // Bus answer: one access cycle per setup, never a stretched ready
  chk_ready_once: assert property (
    setup |=> pready ##1 !pready)
    else $error("ready not a single access cycle");

  // A stray write outside the block still relocks; it is flagged too
  chk_unmapped_err: assert property (
    setup && pwrite && !mapped |=> pslverr && pready)
    else $error("unmapped write not flagged");

  chk_unmapped_read: assert property (
    setup && !pwrite && !mapped |=> pslverr && prdata == 32'h00000000)
    else $error("unmapped read not flagged");

  chk_update_source: assert property (
    update_q |-> $past(low_done))
    else $error("update pulse without low byte write");

  chk_upper_store: assert property (
    ((state_q == ST_WANT_UPPER) and wr_reload(hit_upper)) |=> state_q == ST_WANT_HIGH
      && reload_q[UPPER_LSB +: 8] == $past(wbyte))
    else $error("upper byte not taken in order");

  chk_high_store: assert property (
    ((state_q == ST_WANT_HIGH) and wr_reload(hit_high)) |=> state_q == ST_WANT_LOW
      && reload_q[HIGH_LSB +: 8] == $past(wbyte))
    else $error("high byte not taken in order");

  chk_low_order: assert property (
    ((state_q == ST_WANT_HIGH) and wr_reload(hit_low)) |=> state_q == ST_LOCKED
      && $stable(reload_q) && !update_q)
    else $error("skipped high byte accepted");

  // Lane 0 carries the key, so a write without it counts as a stray write
  chk_strobe_relock: assert property (
    wr_en && hit_ctrl && !pstrb[0] |=> state_q == ST_LOCKED)
    else $error("unstrobed control write did not relock");

  // Reads and idle cycles must leave the sequence exactly where it was
  chk_no_write_hold: assert property (
    !wr_en |=> $stable(state_q) && $stable(reload_q))
    else $error("sequencer moved without a write");

  chk_second_alone: assert property (
    ((state_q != ST_KEY1) and wr_ctrl_key(KEY_SECOND)) |=> !unlocked)
    else $error("second key alone unlocked");
endmodule

// File: include/wdt_unlock_pkg.sv
// Constants for the watchdog reload unlock block
package wdt_unlock_pkg;
  localparam int          ADDR_W         = 16;
  localparam int          DATA_W         = 32;
  // Register indices; byte address is four times the index
  localparam logic [11:0] CTRL_IDX       = 12'hff0;
  localparam logic [11:0] UPPER_IDX      = 12'hff1;
  localparam logic [11:0] HIGH_IDX       = 12'hff2;
  localparam logic [11:0] LOW_IDX        = 12'hff3;
  localparam logic [15:0] CTRL_ADDR      = {2'h0, CTRL_IDX, 2'h0};
  localparam logic [15:0] UPPER_ADDR     = {2'h0, UPPER_IDX, 2'h0};
  localparam logic [15:0] HIGH_ADDR      = {2'h0, HIGH_IDX, 2'h0};
  localparam logic [15:0] LOW_ADDR       = {2'h0, LOW_IDX, 2'h0};
  // Unlock keys
  localparam logic [7:0]  KEY_FIRST      = 8'h55;
  localparam logic [7:0]  KEY_SECOND     = 8'haa;
  // Reload reset value, bytes upper/high/low
  localparam logic [7:0]  UPPER_RST      = 8'h00;
  localparam logic [7:0]  HIGH_RST       = 8'h04;
  localparam logic [7:0]  LOW_RST        = 8'h00;
  localparam logic [23:0] RELOAD_RST     = {UPPER_RST, HIGH_RST, LOW_RST};
  // Field positions of the reload value
  localparam int          UPPER_LSB      = 16;
  localparam int          HIGH_LSB       = 8;
  localparam int          LOW_LSB        = 0;

  typedef enum logic [4:0] {
    ST_LOCKED     = 5'b00001,
    ST_KEY1       = 5'b00010,
    ST_WANT_UPPER = 5'b00100,
    ST_WANT_HIGH  = 5'b01000,
    ST_WANT_LOW   = 5'b10000
  } lock_state_t;
endpackage

// File: verif/watchdog_reload_unlock_tb_top.sv
// Self-checking bench for the watchdog reload unlock block
`timescale 1ns/10ps
module watchdog_reload_unlock_tb_top;
  import wdt_unlock_pkg::*;
  logic        ref_clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  reset_status;
  logic [23:0] count_value;
  logic [23:0] reload_value;
  logic        reload_update;
  logic        unlocked;
  logic [31:0] rd;
  logic        er;
  int          err_count;
  int          checks_done;
  int          pulses;

  watchdog_reload_unlock u_dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reset_status(reset_status), .count_value(count_value), .reload_value(reload_value),
    .reload_update(reload_update), .unlocked(unlocked));

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Counts update pulses so a doubled or missing pulse is seen
  always @(posedge ref_clk)
    if (reload_update === 1'b1)
      pulses++;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Request held until the edge where pready is sampled high
  task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d, input logic [3:0] s);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    pstrb   <= s;
    @(posedge ref_clk);
    penable <= 1'b1;
    // No latency is assumed; only the watchdog ends a hung wait
    do
      @(posedge ref_clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic t_reset_and_reads();
    check({8'h0, reload_value}, {8'h0, RELOAD_RST});
    check({31'h0, unlocked}, 32'h0);
    apb(1'b0, CTRL_ADDR, 8'h00, 4'h0);
    check(rd, {24'h0, reset_status});
    check({31'h0, er}, 32'h0);
    apb(1'b0, HIGH_ADDR, 8'h00, 4'h0);
    check(rd, {24'h0, count_value[15:8]});
    check({31'h0, er}, 32'h0);
  endtask

  task automatic t_locked_write();
    apb(1'b1, UPPER_ADDR, 8'h77, 4'hf);
    check({8'h0, reload_value}, {8'h0, RELOAD_RST});
    apb(1'b1, CTRL_ADDR, KEY_SECOND, 4'hf);
    check({31'h0, unlocked}, 32'h0);
  endtask

  task automatic t_unlock(input logic [23:0] v);
    int p0;
    p0 = pulses;
    apb(1'b1, CTRL_ADDR, KEY_FIRST, 4'hf);
    check({31'h0, unlocked}, 32'h0);
    apb(1'b1, CTRL_ADDR, KEY_SECOND, 4'hf);
    check({31'h0, unlocked}, 32'h1);
    apb(1'b0, CTRL_ADDR, 8'h00, 4'h0);
    check(rd, {24'h0, reset_status});
    apb(1'b1, UPPER_ADDR, v[23:16], 4'hf);
    check({31'h0, unlocked}, 32'h1);
    apb(1'b1, HIGH_ADDR, v[15:8], 4'hf);
    check({31'h0, unlocked}, 32'h1);
    apb(1'b1, LOW_ADDR, v[7:0], 4'hf);
    repeat (2) @(posedge ref_clk);
    #1;
    check({8'h0, reload_value}, {8'h0, v});
    check({31'h0, unlocked}, 32'h0);
    check(pulses - p0, 32'h1);
  endtask

  task automatic t_interrupted(input logic [23:0] old);
    apb(1'b1, CTRL_ADDR, KEY_FIRST, 4'hf);
    apb(1'b1, CTRL_ADDR, KEY_SECOND, 4'hf);
    apb(1'b1, UPPER_ADDR, 8'h11, 4'hf);
    apb(1'b1, 16'h0100, 8'h99, 4'hf);
    check({31'h0, er}, 32'h1);
    check({31'h0, unlocked}, 32'h0);
    apb(1'b0, 16'h0100, 8'h00, 4'h0);
    check(rd, 32'h0);
    check({31'h0, er}, 32'h1);
    apb(1'b1, HIGH_ADDR, 8'h22, 4'hf);
    apb(1'b1, LOW_ADDR, 8'h33, 4'hf);
    check({8'h0, reload_value}, {8'h0, 8'h11, old[15:0]});
  endtask

  task automatic t_wrong_key(input logic [23:0] old);
    int p0;
    p0 = pulses;
    apb(1'b1, CTRL_ADDR, KEY_FIRST, 4'hf);
    apb(1'b1, CTRL_ADDR, 8'h33, 4'hf);
    check({31'h0, unlocked}, 32'h0);
    apb(1'b1, UPPER_ADDR, 8'hee, 4'hf);
    check({8'h0, reload_value}, {8'h0, old});
    apb(1'b1, CTRL_ADDR, KEY_FIRST, 4'hf);
    apb(1'b1, CTRL_ADDR, KEY_SECOND, 4'he);
    check({31'h0, unlocked}, 32'h0);
    apb(1'b1, CTRL_ADDR, KEY_FIRST, 4'hf);
    apb(1'b1, CTRL_ADDR, KEY_SECOND, 4'hf);
    apb(1'b1, UPPER_ADDR, old[23:16], 4'hf);
    apb(1'b1, LOW_ADDR, 8'h77, 4'hf);
    check({31'h0, unlocked}, 32'h0);
    check({8'h0, reload_value}, {8'h0, old});
    repeat (2) @(posedge ref_clk);
    #1;
    check(pulses - p0, 32'h0);
  endtask

  task automatic tally_and_finish();
    if (err_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    #250000;
    err_count++;
    tally_and_finish();
  end

  initial
  begin
    err_count    = 0;
    checks_done  = 0;
    pulses       = 0;
    rst          = 1'b1;
    psel         = 1'b0;
    penable      = 1'b0;
    pwrite       = 1'b0;
    paddr        = 16'h0;
    pwdata       = 32'h0;
    pstrb        = 4'h0;
    reset_status = 8'h5a;
    count_value  = 24'habcdef;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    t_reset_and_reads();
    t_locked_write();
    t_unlock(24'h123456);
    t_unlock(24'h00fe04);
    t_interrupted(24'h00fe04);
    t_wrong_key(24'h11fe04);
    t_unlock(24'hffffff);
    tally_and_finish();
  end
endmodule
